/* pkg/sync_term_consts.svh */
// Register offsets, field positions, reset values and fixed patterns of the sync/term/address matcher
`ifndef SYNC_TERM_CONSTS_SVH
`define SYNC_TERM_CONSTS_SVH

`define ADDR_W              8
`define CONFIG_OFS          8'h00
`define STATUS_OFS          8'h04
`define SYNC_PATTERN_OFS    8'h2C
`define SYNC_MASK_OFS       8'h30
`define TERM_PATTERN_OFS    8'h34
`define TERM_MASK_OFS       8'h38
`define STATION_GROUP_OFS   8'h3C
`define ADDRESS_MASK_OFS    8'h40

`define CFG_HDLC_BIT        0
`define CFG_ADDR_MODE_LSB   1
`define CFG_SYNC_COUNT_LSB  4
`define CFG_TERM_COUNT_LSB  6
`define CFG_WIDTH           8

`define STATION_LSB         16
`define GROUP_LSB           0

`define CONFIG_RST          8'h00
`define PATTERN_RST         32'h0000_0000
`define MASK_RST            32'h0000_0000
`define ADDRESS_RST         32'h0000_0000

`define HDLC_FLAG           8'h7E
`define BITS_PER_BYTE       4'h8

`endif

/* pkg/sync_term_pkg.sv */
// Types shared by the sync/term/address matcher
package sync_term_pkg;

	typedef enum logic [1:0] {
		addr_none,
		addr_eight,
		addr_sixteen,
		addr_spare
	} addr_mode_e;

	typedef enum logic [1:0] {
		st_hunt,
		st_address,
		st_frame
	} rx_state_e;

endpackage

/* pkg/match_if.sv */
// Connection between the frame tracker and one pattern matcher
`timescale 1ns/1ps
interface match_if;
	logic [31:0] window;
	logic [31:0] pattern;
	logic [31:0] mask;
	logic [1:0]  count;
	logic        hdlc;
	logic        hit;

	modport requester (output window, output pattern, output mask, output count, output hdlc, input hit);
	modport matcher   (input window, input pattern, input mask, input count, input hdlc, output hit);
endinterface

/* rtl/pattern_matcher.sv */
// Masked comparison of the latest received bits against one to four pattern bytes
`timescale 1ns/1ps
`include "sync_term_consts.svh"
module pattern_matcher
	import sync_term_pkg::*;
(
	match_if.matcher m
);

	function automatic logic lane_ok(input logic [7:0] rx, input logic [7:0] pat, input logic [7:0] msk);
		return &(~(rx ^ pat) | msk);
	endfunction

	// Byte 0 is the oldest byte of the sequence, so it sits highest in the window
	always_comb begin
		logic [1:0]  used;
		logic [1:0]  idx;
		logic [31:0] moved;
		logic [7:0]  pat;
		logic        ok;
		used  = m.hdlc ? 2'd0 : m.count;
		idx   = 2'd0;
		moved = 32'h0000_0000;
		pat   = 8'h00;
		ok    = 1'b1;
		for (int k = 0; k < 4; k++) begin
			if (2'(k) <= used) begin
				idx   = used - 2'(k);
				moved = m.window >> {idx, 3'b000};
				pat   = (k == 0 && m.hdlc) ? `HDLC_FLAG : m.pattern[8*k +: 8];
				ok    = ok & lane_ok(moved[7:0], pat, m.mask[8*k +: 8]);
			end
		end
		m.hit = ok;
	end

endmodule

/* rtl/sync_term_address_match.sv */
// Receive-side sync hunt, frame termination and station/group address filter
`timescale 1ns/1ps
`include "sync_term_consts.svh"
module sync_term_address_match
	import sync_term_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic [`ADDR_W-1:0]   addr,
	input  wire logic [31:0]          wr_data,
	input  wire logic                 wr_en,
	input  wire logic                 rd_en,
	output logic      [31:0]          rd_data,
	input  wire logic                 rx_clk_pin,
	input  wire logic                 rx_data_pin,
	output logic                      frame_active,
	output logic                      frame_start,
	output logic                      frame_end,
	output logic                      frame_reject,
	output logic      [7:0]           rx_byte,
	output logic                      rx_byte_valid
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [`CFG_WIDTH-1:0] channel_config_zero;
	logic [31:0]           sync_pattern;
	logic [31:0]           sync_pattern_mask;
	logic [31:0]           termination_pattern;
	logic [31:0]           termination_pattern_mask;
	logic [31:0]           receive_station_group_address;
	logic [31:0]           address_bit_mask;
	logic [7:0]            reject_count;

	rx_state_e             state;
	logic [31:0]           shift;
	logic [3:0]            bit_cnt;
	logic                  bit_new;
	logic                  station_hit_last;
	logic                  group_hit_last;

	logic                  hdlc;
	addr_mode_e            addr_mode;
	logic [1:0]            sync_byte_count;
	logic [1:0]            termination_byte_count;

	assign hdlc                   = channel_config_zero[`CFG_HDLC_BIT];
	assign addr_mode              = addr_mode_e'(channel_config_zero[`CFG_ADDR_MODE_LSB +: 2]);
	assign sync_byte_count        = channel_config_zero[`CFG_SYNC_COUNT_LSB +: 2];
	assign termination_byte_count = channel_config_zero[`CFG_TERM_COUNT_LSB +: 2];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			channel_config_zero           <= `CONFIG_RST;
			sync_pattern                  <= `PATTERN_RST;
			sync_pattern_mask             <= `MASK_RST;
			termination_pattern           <= `PATTERN_RST;
			termination_pattern_mask      <= `MASK_RST;
			receive_station_group_address <= `ADDRESS_RST;
			address_bit_mask              <= `MASK_RST;
		end else if (wr_en) begin
			case (addr)
				`CONFIG_OFS:        channel_config_zero           <= wr_data[`CFG_WIDTH-1:0];
				`SYNC_PATTERN_OFS:  sync_pattern                  <= wr_data;
				`SYNC_MASK_OFS:     sync_pattern_mask             <= wr_data;
				`TERM_PATTERN_OFS:  termination_pattern           <= wr_data;
				`TERM_MASK_OFS:     termination_pattern_mask      <= wr_data;
				`STATION_GROUP_OFS: receive_station_group_address <= wr_data;
				`ADDRESS_MASK_OFS:  address_bit_mask              <= wr_data;
				default: ;
			endcase
		end
	end

	// Unmapped reads return zero; data stands for the cycle after the strobe only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_data <= 32'h0000_0000;
		end else if (rd_en) begin
			case (addr)
				`CONFIG_OFS:        rd_data <= {24'h00_0000, channel_config_zero};
				`STATUS_OFS:        rd_data <= {16'h0000, reject_count, 4'h0, group_hit_last, station_hit_last, state};
				`SYNC_PATTERN_OFS:  rd_data <= sync_pattern;
				`SYNC_MASK_OFS:     rd_data <= sync_pattern_mask;
				`TERM_PATTERN_OFS:  rd_data <= termination_pattern;
				`TERM_MASK_OFS:     rd_data <= termination_pattern_mask;
				`STATION_GROUP_OFS: rd_data <= receive_station_group_address;
				`ADDRESS_MASK_OFS:  rd_data <= address_bit_mask;
				default:            rd_data <= 32'h0000_0000;
			endcase
		end else begin
			rd_data <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Line sampling
	// ----------------------------------------------------------------
	logic rx_clk_s1;
	logic rx_clk_s2;
	logic rx_clk_s3;
	logic rx_data_s1;
	logic rx_data_s2;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_clk_s1  <= 1'b0;
			rx_clk_s2  <= 1'b0;
			rx_clk_s3  <= 1'b0;
			rx_data_s1 <= 1'b0;
			rx_data_s2 <= 1'b0;
		end else begin
			rx_clk_s1  <= rx_clk_pin;
			rx_clk_s2  <= rx_clk_s1;
			rx_clk_s3  <= rx_clk_s2;
			rx_data_s1 <= rx_data_pin;
			rx_data_s2 <= rx_data_s1;
		end
	end

	// Newest bit enters at bit 0; the matchers look one cycle after the shift
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shift   <= 32'h0000_0000;
			bit_new <= 1'b0;
		end else begin
			bit_new <= rx_clk_s2 & ~rx_clk_s3;
			if (rx_clk_s2 & ~rx_clk_s3) begin
				shift <= {shift[30:0], rx_data_s2};
			end
		end
	end

	// ----------------------------------------------------------------
	// Pattern matchers
	// ----------------------------------------------------------------
	match_if sync_link ();
	match_if term_link ();

	assign sync_link.window  = shift;
	assign sync_link.pattern = sync_pattern;
	assign sync_link.mask    = sync_pattern_mask;
	assign sync_link.count   = sync_byte_count;
	assign sync_link.hdlc    = hdlc;
	assign term_link.window  = shift;
	assign term_link.pattern = termination_pattern;
	assign term_link.mask    = termination_pattern_mask;
	assign term_link.count   = termination_byte_count;
	assign term_link.hdlc    = hdlc;

	pattern_matcher sync_match (.m(sync_link));
	pattern_matcher term_match (.m(term_link));

	// ----------------------------------------------------------------
	// Address filter
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [15:0] rx, input logic [15:0] ref_addr,
		input logic [15:0] msk, input logic wide);
		logic [15:0] ok;
		ok = ~(rx ^ ref_addr) | msk;
		return wide ? &ok : &ok[7:0];
	endfunction

	logic wide_addr;
	logic addr_last;
	logic station_hit;
	logic group_hit;

	assign wide_addr   = (addr_mode == addr_sixteen);
	assign addr_last   = (bit_cnt == (wide_addr ? 4'hF : 4'h7));
	// In 16-bit mode the first address byte received is the high byte; an 8-bit address is matched against the low byte
	assign station_hit = addr_hit(shift[15:0], receive_station_group_address[`STATION_LSB +: 16],
		address_bit_mask[`STATION_LSB +: 16], wide_addr);
	assign group_hit   = addr_hit(shift[15:0], receive_station_group_address[`GROUP_LSB +: 16],
		address_bit_mask[`GROUP_LSB +: 16], wide_addr);

	// ----------------------------------------------------------------
	// Frame tracking
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state        <= st_hunt;
			bit_cnt      <= 4'h0;
			frame_start  <= 1'b0;
			frame_end    <= 1'b0;
			frame_reject <= 1'b0;
		end else begin
			frame_start  <= 1'b0;
			frame_end    <= 1'b0;
			frame_reject <= 1'b0;
			if (bit_new) begin
				case (state)
					st_hunt: begin
						bit_cnt <= 4'h0;
						if (sync_link.hit) begin
							if (addr_mode == addr_none) begin
								state       <= st_frame;
								frame_start <= 1'b1;
							end else begin
								state <= st_address;
							end
						end
					end
					st_address: begin
						// A repeated flag in the first byte slot restarts the address
						if (bit_cnt == 4'h7 && sync_link.hit) begin
							bit_cnt <= 4'h0;
						end else if (addr_last) begin
							bit_cnt <= 4'h0;
							if (station_hit || group_hit) begin
								state       <= st_frame;
								frame_start <= 1'b1;
							end else begin
								state        <= st_hunt;
								frame_reject <= 1'b1;
							end
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					st_frame: begin
						bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
						if (term_link.hit) begin
							state     <= st_hunt;
							frame_end <= 1'b1;
						end
					end
					default: begin
						state <= st_hunt;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			station_hit_last <= 1'b0;
			group_hit_last   <= 1'b0;
			reject_count     <= 8'h00;
		end else if (bit_new && state == st_address && addr_last && !(bit_cnt == 4'h7 && sync_link.hit)) begin
			station_hit_last <= station_hit;
			group_hit_last   <= group_hit;
			if (!(station_hit || group_hit)) begin
				reject_count <= reject_count + 8'h01;
			end
		end
	end

	// Bytes of the frame body go out as they complete, except a byte whose last bit completes the termination match
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_byte       <= 8'h00;
			rx_byte_valid <= 1'b0;
			frame_active  <= 1'b0;
		end else begin
			rx_byte_valid <= bit_new && state == st_frame && bit_cnt == 4'h7 && !term_link.hit;
			if (bit_new && state == st_frame && bit_cnt == 4'h7) begin
				rx_byte <= shift[7:0];
			end
			frame_active <= (state == st_frame);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking chk_clk @(posedge ref_clk); endclocking
	default disable iff (rst);

	hunt_holds_a: assert property (state == st_hunt && bit_new && !sync_link.hit |=> state == st_hunt)
		else $error("left hunt without a sync match");
	hdlc_flag_a: assert property (hdlc && state == st_hunt && bit_new && shift[7:0] == `HDLC_FLAG
		&& sync_pattern_mask[7:0] == 8'h00 |=> state != st_hunt)
		else $error("HDLC flag not taken as sync");
	sync_masked_a: assert property (!hdlc && sync_byte_count == 2'd0 && sync_pattern_mask[7:0] == 8'hFF
		&& state == st_hunt && bit_new |=> state != st_hunt)
		else $error("fully masked sync byte did not match");
	sync_exact_a: assert property (!hdlc && sync_byte_count == 2'd0 && sync_pattern_mask[7:0] == 8'h00
		&& state == st_hunt && bit_new && shift[7:0] != sync_pattern[7:0] |=> state == st_hunt)
		else $error("unmasked sync mismatch accepted");
	term_masked_a: assert property (!hdlc && termination_byte_count == 2'd0 && termination_pattern_mask[7:0] == 8'hFF
		&& state == st_frame && bit_new |=> frame_end ##1 !frame_active)
		else $error("fully masked termination did not end frame");
	hdlc_term_a: assert property (hdlc && state == st_frame && bit_new && shift[7:0] == `HDLC_FLAG
		&& termination_pattern_mask[7:0] == 8'h00 |=> frame_end && state == st_hunt)
		else $error("HDLC flag did not end frame");
	term_exact_a: assert property (state == st_frame && bit_new && !term_link.hit |=> !frame_end)
		else $error("frame ended without termination match");
	start_after_addr_a: assert property (frame_start && addr_mode != addr_none |-> $past(state) == st_address)
		else $error("frame start did not follow the address field");
	reject_restart_a: assert property (frame_reject |-> state == st_hunt && !frame_start ##1 !frame_active)
		else $error("rejected frame not discarded");
	station_low_a: assert property (addr_mode == addr_eight && state == st_address && bit_new && bit_cnt == 4'h7
		&& !sync_link.hit && shift[7:0] == receive_station_group_address[23:16] |=> frame_start)
		else $error("8-bit station address not accepted");
	group_wide_a: assert property (addr_mode == addr_sixteen && state == st_address && bit_new && bit_cnt == 4'hF
		&& shift[15:0] == receive_station_group_address[15:0] |=> frame_start ##1 frame_active)
		else $error("16-bit group address not accepted");
	mask_all_a: assert property (address_bit_mask == 32'hFFFF_FFFF && state == st_address && bit_new && addr_last
		&& !(bit_cnt == 4'h7 && sync_link.hit) |=> !frame_reject)
		else $error("fully masked address rejected");

	accept_c: cover property (state == st_address ##[1:300] frame_start ##[1:1000] frame_end);
	reject_c: cover property (frame_reject);
	byte_c:   cover property (frame_active && rx_byte_valid);

endmodule

/* bench/remote_station.sv */
// Remote station model that sends synchronous bytes to the receiver, most significant bit first
`timescale 1ns/1ps
module remote_station (
	input  wire logic ref_clk,
	output logic      rx_clk_pin,
	output logic      rx_data_pin
);
	// Bit clock stands low between bytes; data is sampled by the receiver on the rising edge
	initial begin
		rx_clk_pin  = 1'b0;
		rx_data_pin = 1'b1;
	end

	// half: ref_clk cycles per clock phase, at least 3, larger for a slow station
	task automatic send_byte(input logic [7:0] b, input int half);
		for (int i = 7; i >= 0; i--) begin
			@(posedge ref_clk);
			rx_data_pin <= b[i];
			repeat (half) @(posedge ref_clk);
			rx_clk_pin <= 1'b1;
			repeat (half) @(posedge ref_clk);
			rx_clk_pin <= 1'b0;
		end
		// Hold time is over: the line no longer shows the last bit
		rx_data_pin <= ~b[0];
	endtask
endmodule

/* bench/test_sync_term_address_match.sv */
// Self-checking bench for the sync hunt, termination and address filter
`timescale 1ns/1ps
`include "sync_term_consts.svh"
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module test_sync_term_address_match;
	logic              ref_clk = 1'b0;
	logic              rst     = 1'b1;
	logic [`ADDR_W-1:0] addr   = '0;
	logic [31:0]       wr_data = '0;
	logic              wr_en   = 1'b0;
	logic              rd_en   = 1'b0;
	logic [31:0]       rd_data;
	logic              rx_clk_pin;
	logic              rx_data_pin;
	logic              frame_active;
	logic              frame_start;
	logic              frame_end;
	logic              frame_reject;
	logic [7:0]        rx_byte;
	logic              rx_byte_valid;
	logic [7:0]        last_byte;
	int                failures = 0;
	int                samples_checked = 0;
	int                starts;
	int                ends;
	int                rejects;
	int                valids;
	int                half = 4;
	localparam logic [7:0] REG_OFS [7] = '{`CONFIG_OFS, `SYNC_PATTERN_OFS, `SYNC_MASK_OFS, `TERM_PATTERN_OFS,
		`TERM_MASK_OFS, `STATION_GROUP_OFS, `ADDRESS_MASK_OFS};

	always #50 ref_clk = ~ref_clk;

	sync_term_address_match uut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin),
		.frame_active(frame_active), .frame_start(frame_start), .frame_end(frame_end),
		.frame_reject(frame_reject), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid));

	remote_station station (.ref_clk(ref_clk), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin));

	// ----------------------------------------
	// Pulse monitor, cleared by every reset
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			starts    <= 0;
			ends      <= 0;
			rejects   <= 0;
			valids    <= 0;
			last_byte <= 8'h00;
		end else begin
			starts  <= starts + ((frame_start === 1'b1) ? 1 : 0);
			ends    <= ends + ((frame_end === 1'b1) ? 1 : 0);
			rejects <= rejects + ((frame_reject === 1'b1) ? 1 : 0);
			valids  <= valids + ((rx_byte_valid === 1'b1) ? 1 : 0);
			if (rx_byte_valid === 1'b1)
				last_byte <= rx_byte;
		end
	end

	// ----------------------------------------
	// Bus, link and report helpers
	// ----------------------------------------
	task automatic do_reset;
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		// Pin synchronisers need a few cycles to settle
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr_en   <= 1'b1;
		addr    <= a;
		wr_data <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		d = rd_data;
	endtask

	task automatic tx(input logic [7:0] b);
		station.send_byte(b, half);
	endtask

	task automatic expect_frames(input int s, input int e, input int r, input int v);
		// A late spurious pulse must still land inside this window
		repeat (8) @(posedge ref_clk);
		for (int n = 0; n < 40 && !(starts == s && ends == e && rejects == r && valids == v); n++)
			@(posedge ref_clk);
		`CHK("frame_start count", s, starts)
		`CHK("frame_end count", e, ends)
		`CHK("frame_reject count", r, rejects)
		`CHK("rx_byte_valid count", v, valids)
	endtask

	task complete_run;
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic check_registers;
		logic [31:0] v;
		logic [31:0] pat;
		do_reset();
		for (int i = 0; i < 7; i++) begin
			reg_read(REG_OFS[i], v);
			`CHK("register reset value", 32'h0000_0000, v)
		end
		for (int i = 0; i < 7; i++) begin
			pat = 32'hC3A5_5A30 + 32'(i);
			reg_write(REG_OFS[i], pat);
			reg_read(REG_OFS[i], v);
			`CHK("register readback", (i == 0) ? {24'h000000, pat[7:0]} : pat, v)
		end
		reg_write(`STATUS_OFS, 32'hFFFF_FFFF);
		reg_read(`STATUS_OFS, v);
		`CHK("status after write", 32'h0000_0000, v)
		reg_read(8'h44, v);
		`CHK("unmapped read", 32'h0000_0000, v)
	endtask

	task automatic hdlc_frame;
		do_reset();
		// All four bytes selected, yet HDLC must use only the fixed flag
		reg_write(`CONFIG_OFS, 32'h0000_00F1);
		reg_write(`SYNC_PATTERN_OFS, 32'h1122_3344);
		reg_write(`TERM_PATTERN_OFS, 32'h5566_7788);
		half = 6;
		tx(8'h7E);
		expect_frames(1, 0, 0, 0);
		tx(8'hA5);
		expect_frames(1, 0, 0, 1);
		`CHK("body byte", 8'hA5, last_byte)
		`CHK("frame_active in frame", 1'b1, frame_active)
		tx(8'h7E);
		expect_frames(1, 1, 0, 1);
		repeat (2) @(posedge ref_clk);
		`CHK("frame_active after end", 1'b0, frame_active)
	endtask

	task automatic two_byte_frame;
		do_reset();
		reg_write(`CONFIG_OFS, 32'h0000_0050);
		reg_write(`SYNC_PATTERN_OFS, 32'h1111_B3C5);
		reg_write(`TERM_PATTERN_OFS, 32'h2222_F00F);
		half = 3;
		tx(8'hC5);
		expect_frames(0, 0, 0, 0);
		tx(8'hB3);
		expect_frames(1, 0, 0, 0);
		tx(8'h0F);
		expect_frames(1, 0, 0, 1);
		`CHK("body byte", 8'h0F, last_byte)
		tx(8'hF0);
		expect_frames(1, 1, 0, 1);
	endtask

	task automatic masked_frame;
		do_reset();
		reg_write(`CONFIG_OFS, 32'h0000_0000);
		reg_write(`SYNC_PATTERN_OFS, 32'h0000_005A);
		reg_write(`SYNC_MASK_OFS, 32'h0000_000F);
		reg_write(`TERM_PATTERN_OFS, 32'h0000_0080);
		reg_write(`TERM_MASK_OFS, 32'h0000_0001);
		half = 4;
		tx(8'hD3);
		expect_frames(0, 0, 0, 0);
		tx(8'h53);
		expect_frames(1, 0, 0, 0);
		tx(8'h81);
		expect_frames(1, 1, 0, 0);
	endtask

	task automatic address_sixteen;
		logic [31:0] v;
		do_reset();
		reg_write(`CONFIG_OFS, 32'h0000_0005);
		reg_write(`STATION_GROUP_OFS, 32'h1234_AB00);
		reg_write(`ADDRESS_MASK_OFS, 32'h0000_00FF);
		tx(8'h7E);
		tx(8'h12);
		tx(8'h34);
		expect_frames(1, 0, 0, 0);
		tx(8'h7E);
		expect_frames(1, 1, 0, 0);
		tx(8'h7E);
		tx(8'h12);
		tx(8'h35);
		expect_frames(1, 1, 1, 0);
		reg_read(`STATUS_OFS, v);
		`CHK("rejected frame count", 8'h01, v[15:8])
		tx(8'h7E);
		tx(8'hAB);
		tx(8'h77);
		expect_frames(2, 1, 1, 0);
		// Group hit without station hit, receiver now in the frame body
		reg_read(`STATUS_OFS, v);
		`CHK("status hits and state", 4'hA, v[3:0])
		tx(8'h7E);
		expect_frames(2, 2, 1, 0);
	endtask

	task automatic address_eight;
		do_reset();
		reg_write(`CONFIG_OFS, 32'h0000_0003);
		reg_write(`STATION_GROUP_OFS, 32'hEE12_9944);
		tx(8'h7E);
		tx(8'h12);
		expect_frames(1, 0, 0, 0);
		tx(8'h7E);
		tx(8'h7E);
		tx(8'h44);
		expect_frames(2, 1, 0, 0);
		tx(8'h7E);
		tx(8'h7E);
		tx(8'hEE);
		expect_frames(2, 2, 1, 0);
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		complete_run();
	end

	initial begin
		check_registers();
		hdlc_frame();
		two_byte_frame();
		masked_frame();
		address_sixteen();
		address_eight();
		complete_run();
	end
endmodule
